// ---- verif/pmseq_far_model.sv ----
// wake-source peripherals model on the sequencer's far side
`timescale 1ns/1ps
module pmseq_far_model (
  // clock
  input wire logic sys_clk,
  // wake lines toward the sequencer
  output logic [3:0] wake_irq,
  output logic external_reset_pin,
  output logic watchdog_timeout,
  output logic precise_voltage_reset
);
  // idle levels: irqs low, reset pin pulled up
  initial begin
    wake_irq = 4'h0;
    external_reset_pin = 1'b1;
    watchdog_timeout = 1'b0;
    precise_voltage_reset = 1'b0;
  end
  // raise one source for n cycles; sel 0-3 irq, 4 pin, 5 dog, 6 supply
  task automatic fire(input int sel, input int n);
    // keep pin toggles at least 50 us apart
    if (sel == 0) repeat (10000) @(posedge sys_clk);
    if (sel < 4) wake_irq[sel] <= 1'b1;
    else if (sel == 4) external_reset_pin <= 1'b0;
    else if (sel == 5) watchdog_timeout <= 1'b1;
    else precise_voltage_reset <= 1'b1;
    repeat (n) @(posedge sys_clk);
    // release back to idle levels
    wake_irq <= 4'h0;
    external_reset_pin <= 1'b1;
    watchdog_timeout <= 1'b0;
    precise_voltage_reset <= 1'b0;
  endtask
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench for the power mode sequencer
`timescale 1ns/1ps
`include "pmseq_defines.svh"
module tb_top;
  // clock, reset, register port
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  // wake lines from the model
  logic [3:0] wake_irq;
  logic external_reset_pin;
  logic watchdog_timeout;
  logic precise_voltage_reset;
  // pins and power outputs
  logic [7:0] gpio_out_in = 8'h00;
  logic [7:0] gpio_out_pins;
  logic fast_startup = 1'b1;
  logic startup_clk_48m;
  logic [7:0] subsys_pwr;
  logic cpu_en;
  logic irq;
  pmseq_pkg::pmseq_mode_type mode_out;
  pmseq_pkg::pmseq_boost_type boost;
  // bookkeeping
  int n_errors = 0;
  int comparisons = 0;
  int cnt;
  logic [31:0] v;
  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;
  pmseq_top i_pmseq_top (.sys_clk(sys_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wake_irq(wake_irq),
    .external_reset_pin(external_reset_pin),
    .watchdog_timeout(watchdog_timeout),
    .precise_voltage_reset(precise_voltage_reset),
    .gpio_out_in(gpio_out_in), .gpio_out_pins(gpio_out_pins),
    .fast_startup(fast_startup), .startup_clk_48m(startup_clk_48m),
    .subsys_pwr(subsys_pwr), .cpu_en(cpu_en), .mode_out(mode_out),
    .boosted_supply_output(boost), .irq(irq));
  pmseq_far_model i_pmseq_far_model (.sys_clk(sys_clk),
    .wake_irq(wake_irq), .external_reset_pin(external_reset_pin),
    .watchdog_timeout(watchdog_timeout),
    .precise_voltage_reset(precise_voltage_reset));
  // value compare
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  // cycle-count window compare
  task automatic chk_rng(input string s, input int lo, input int hi);
    comparisons++;
    if (cnt < lo || cnt > hi) begin
      n_errors++;
      $display("ERROR %s expected %0d..%0d seen %0d", s, lo, hi, cnt);
    end
  endtask
  // one-cycle write strobe, one idle edge before the next access
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  // read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge sys_clk);
  endtask
  // wait for a mode, bounded, counting cycles
  task automatic wait_mode(input pmseq_pkg::pmseq_mode_type m,
                           input int lim);
    cnt = 0;
    while (mode_out !== m && cnt < lim) begin
      @(posedge sys_clk);
      cnt++;
    end
  endtask
  // count boost clock rises over n cycles
  task automatic rises(input int n);
    logic p;
    p = boost.boost_clk;
    cnt = 0;
    repeat (n) begin
      @(posedge sys_clk);
      if (boost.boost_clk && !p) cnt++;
      p = boost.boost_clk;
    end
  endtask
  // counts, verdict, end of run
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard, well past the expected run
  initial begin
    #400000;
    n_errors++;
    report_and_stop;
  end
  // main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rd(`PMSEQ_ADDR_TPL);
    chk("tpl", 32'hff, v);
    rd(8'h24);
    chk("unmapped", 32'h0, v);
    chk("boost on", 1'b1, boost.boost_active);
    // level clamp and steps, fixed switching rate
    wr(`PMSEQ_ADDR_BOOST, 32'h3f);
    @(posedge sys_clk);
    chk("vsel max", 32'h20, boost.boost_vsel);
    wr(`PMSEQ_ADDR_BOOST, 32'h1f);
    rises(4 * `PMSEQ_BOOST_DIV);
    chk("vsel", 32'h1f, boost.boost_vsel);
    chk("boost rises", 32'h4, cnt);
    // alternate active
    wr(`PMSEQ_ADDR_ALT, 32'h0c);
    wr(`PMSEQ_ADDR_CTRL, 32'h1);
    repeat (3) @(posedge sys_clk);
    chk("alt mode", pmseq_pkg::MD_ALT, mode_out);
    chk("alt pwr", 32'h0c, subsys_pwr);
    chk("alt cpu", 1'b0, cpu_en);
    chk("alt boost", 1'b1, boost.boost_active);
    // sleep with cpu off; disabled source ignored, enabled one wakes
    wr(`PMSEQ_ADDR_IRQMSK, 32'hf);
    wr(`PMSEQ_ADDR_WAKEEN, 32'h2);
    wr(`PMSEQ_ADDR_CTRL, 32'h6);
    repeat (12) @(posedge sys_clk);
    chk("sleep pwr", `PMSEQ_SLEEP_KEEP, subsys_pwr);
    i_pmseq_far_model.fire(2, 2);
    repeat (20) @(posedge sys_clk);
    chk("no wake", pmseq_pkg::MD_SLEEP, mode_out);
    i_pmseq_far_model.fire(1, 1);
    wait_mode(pmseq_pkg::MD_ACTIVE, 4000);
    chk_rng("sleep resume", 2900, 3100);
    chk("cpu back", 1'b1, cpu_en);
    rd(`PMSEQ_ADDR_IRQST);
    chk("wake flags", 32'h9, v & 32'hf);
    chk("irq up", 1'b1, irq);
    wr(`PMSEQ_ADDR_IRQST, 32'hf);
    @(posedge sys_clk);
    chk("irq cleared", 1'b0, irq);
    // wake during entry is kept
    wr(`PMSEQ_ADDR_CTRL, 32'h2);
    i_pmseq_far_model.fire(1, 1);
    wait_mode(pmseq_pkg::MD_SLEEP, 5);
    wait_mode(pmseq_pkg::MD_ACTIVE, 4000);
    chk_rng("pending wake", 2900, 3100);
    // each reset source wakes from sleep
    for (int s = 4; s < 7; s++) begin
      wr(`PMSEQ_ADDR_CTRL, 32'h2);
      repeat (10) @(posedge sys_clk);
      i_pmseq_far_model.fire(s, 2);
      wait_mode(pmseq_pkg::MD_ACTIVE, 4000);
      chk_rng("reset wake", 2900, 3100);
      rd(`PMSEQ_ADDR_IRQST);
      chk("reset flag", 1'b1, v[2]);
      wr(`PMSEQ_ADDR_IRQST, 32'hf);
    end
    // standby boost in sleep, timer refresh wake
    wr(`PMSEQ_ADDR_BOOST, 32'h11f);
    wr(`PMSEQ_ADDR_WAKEEN, 32'h8);
    wr(`PMSEQ_ADDR_TIMER, 32'd6000);
    wr(`PMSEQ_ADDR_CTRL, 32'h2);
    repeat (20) @(posedge sys_clk);
    chk("standby", 1'b0, boost.boost_active);
    rises(2 * `PMSEQ_BOOST_DIV);
    chk("gated clk", 32'h0, cnt);
    wait_mode(pmseq_pkg::MD_ACTIVE, 10000);
    chk_rng("refresh wake", 2500, 9500);
    chk("boost active", 1'b1, boost.boost_active);
    wr(`PMSEQ_ADDR_IRQST, 32'hf);
    repeat (6100) @(posedge sys_clk);
    wr(`PMSEQ_ADDR_TIMER, 32'h0);
    rd(`PMSEQ_ADDR_IRQST);
    chk("tick again", 1'b1, v[1]);
    wr(`PMSEQ_ADDR_IRQST, 32'hd);
    wr(`PMSEQ_ADDR_IRQMSK, 32'h0);
    @(posedge sys_clk);
    chk("masked irq", 1'b0, irq);
    wr(`PMSEQ_ADDR_IRQMSK, 32'h2);
    @(posedge sys_clk);
    chk("unmasked irq", 1'b1, irq);
    wr(`PMSEQ_ADDR_IRQST, 32'h2);
    @(posedge sys_clk);
    chk("w1c irq", 1'b0, irq);
    // hibernate holds pins, ignores non-pin wakes
    wr(`PMSEQ_ADDR_BOOST, 32'h1f);
    wr(`PMSEQ_ADDR_WAKEEN, 32'hf);
    gpio_out_in <= 8'ha5;
    wr(`PMSEQ_ADDR_CTRL, 32'h3);
    repeat (12) @(posedge sys_clk);
    gpio_out_in <= 8'h5a;
    i_pmseq_far_model.fire(1, 2);
    repeat (20) @(posedge sys_clk);
    chk("hib kept", pmseq_pkg::MD_HIB, mode_out);
    chk("held pins", 8'ha5, gpio_out_pins);
    chk("hib boost", 1'b0, boost.boost_active);
    i_pmseq_far_model.fire(0, 2);
    wait_mode(pmseq_pkg::MD_ACTIVE, 21000);
    chk_rng("hib resume", 1, 19999);
    rd(`PMSEQ_ADDR_ALT);
    chk("alt kept", 32'h0c, v);
    // slow startup clock select
    fast_startup <= 1'b0;
    @(posedge sys_clk);
    @(posedge sys_clk);
    chk("slow start", 1'b0, startup_clk_48m);
    fast_startup <= 1'b1;
    @(posedge sys_clk);
    @(posedge sys_clk);
    chk("fast start", 1'b1, startup_clk_48m);
    report_and_stop;
  end
endmodule

// ---- verilog/pmseq_defines.svh ----
// constants for the power mode and boost sequencer
// Functional notes
// - alternate active powers reduced subsystem set
// - sleep exit waits 15 us then active
// - hibernate keeps config, memory, held outputs
// - hibernate exits only on pin interrupt; code also exits it on external reset pin low
// - any configured wake returns to active
// - wake interrupt sources individually enabled; code shares enable bit 3 between wake_irq[3] and the timer
// - periodic wake timer issues recurring interrupts
// - reset wakes: pin, watchdog, voltage reset
// - boost level 1.8 to 5.0 V, 100 mV
// - boost switches at fixed 400 kHz
// - boost has active and standby modes
// - boost active in active or alternate active
// - sleep standby boost needs periodic refresh
// - slow startup uses 12 MHz not 48
// - wake forces active and processor enable
// - sleep disables most resources regardless
`ifndef PMSEQ_DEFINES_SVH
`define PMSEQ_DEFINES_SVH
`define PMSEQ_CLK_MHZ 200
`define PMSEQ_SLEEP_RESUME_NS 15000
`define PMSEQ_SLEEP_RESUME_CYC (`PMSEQ_SLEEP_RESUME_NS*`PMSEQ_CLK_MHZ/1000)
`define PMSEQ_HIB_RESUME_NS 100000
`define PMSEQ_HIB_RESUME_CYC 19000
`define PMSEQ_BOOST_HZ 400000
`define PMSEQ_BOOST_DIV (`PMSEQ_CLK_MHZ*1000000/`PMSEQ_BOOST_HZ)
`define PMSEQ_ENTRY_CYC 4
`define PMSEQ_VSEL_MAX 8'h20
`define PMSEQ_ADDR_CTRL 8'h00
`define PMSEQ_ADDR_STAT 8'h04
`define PMSEQ_ADDR_WAKEEN 8'h08
`define PMSEQ_ADDR_TPL 8'h0c
`define PMSEQ_ADDR_ALT 8'h10
`define PMSEQ_ADDR_BOOST 8'h14
`define PMSEQ_ADDR_TIMER 8'h18
`define PMSEQ_ADDR_IRQST 8'h1c
`define PMSEQ_ADDR_IRQMSK 8'h20
`define PMSEQ_TPL_RST 8'hff
`define PMSEQ_W_PIN 0
`define PMSEQ_W_TIMER 3
`define PMSEQ_SLEEP_KEEP 8'h03
`endif

// ---- verilog/pmseq_pkg.sv ----
// types for the power mode and boost sequencer
package pmseq_pkg;
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b000,
    ST_ALT = 3'b001,
    ST_ENTER_SLEEP = 3'b010,
    ST_SLEEP = 3'b011,
    ST_ENTER_HIB = 3'b100,
    ST_HIB = 3'b101,
    ST_RESUME = 3'b110
  } pmseq_state_type;
  typedef enum logic [1:0] {
    MD_ACTIVE = 2'b00,
    MD_ALT = 2'b01,
    MD_SLEEP = 2'b10,
    MD_HIB = 2'b11
  } pmseq_mode_type;
  typedef struct packed {
    logic boost_active;
    logic boost_clk;
    logic [5:0] boost_vsel;
  } pmseq_boost_type;
endpackage

// ---- verilog/pmseq_top.sv ----
// power mode sequencer with boost control and register port
`timescale 1ns/1ps
`include "pmseq_defines.svh"
module pmseq_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // wake sources: 0 pin, 1 comparator, 2 logic, 3 supervisor
  input wire logic [3:0] wake_irq,
  input wire logic external_reset_pin,
  input wire logic watchdog_timeout,
  input wire logic precise_voltage_reset,
  // pin hold and startup clock
  input wire logic [7:0] gpio_out_in,
  output logic [7:0] gpio_out_pins,
  input wire logic fast_startup,
  output logic startup_clk_48m,
  // power outputs
  output logic [7:0] subsys_pwr,
  output logic cpu_en,
  output pmseq_pkg::pmseq_mode_type mode_out,
  output pmseq_pkg::pmseq_boost_type boosted_supply_output,
  output logic irq
);
  // decode helper used by both write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  pmseq_pkg::pmseq_state_type state_ff, nxt_state;
  logic [1:0] req_mode_ff; // requested mode, write pulses the request
  logic req_go_ff; // request pending
  logic [3:0] wake_en_ff; // wake interrupt enables
  logic [7:0] tpl_ff; // active template
  logic [7:0] alt_ff; // alternate active template
  logic [5:0] vsel_ff; // boost level, 0 = 1.8 V
  logic boost_sleep_stby_ff; // boost standby wanted in sleep
  logic [31:0] timer_per_ff; // wake timer period
  logic [31:0] timer_cnt_ff;
  logic [3:0] irq_st_ff; // 0 wake, 1 timer, 2 reset, 3 mode done
  logic [3:0] irq_msk_ff;
  logic cpu_off_ff; // firmware cpu disable
  logic [7:0] hold_ff; // held gpio values
  logic pend_ff; // wake held during transition
  logic [15:0] dly_ff; // transition delay counter
  logic [7:0] bdiv_ff; // boost oscillator divider
  logic bclk_ff;
  logic [31:0] rdata_ff;
  logic [7:0] gpio_ff;
  logic from_hib_ff; // resume began in hibernate

  // wake classification
  wire timer_tick = (timer_per_ff != 32'h0) &&
                    (timer_cnt_ff == timer_per_ff - 32'h1);
  wire [3:0] wake_vec = {wake_irq[3:1], wake_irq[0]};
  wire irq_wake = |(wake_vec & wake_en_ff) |
                  (timer_tick & wake_en_ff[`PMSEQ_W_TIMER]);
  wire rst_wake = ~external_reset_pin | watchdog_timeout |
                  precise_voltage_reset;
  wire pin_wake = (wake_irq[`PMSEQ_W_PIN] & wake_en_ff[`PMSEQ_W_PIN]) |
                  ~external_reset_pin;
  wire any_wake = irq_wake | rst_wake;
  wire do_wake = (state_ff == pmseq_pkg::ST_SLEEP && (any_wake | pend_ff)) ||
                 (state_ff == pmseq_pkg::ST_HIB && (pin_wake | pend_ff));
  // refresh wake for a standby boost in sleep comes from the timer
  wire boost_refresh = (state_ff == pmseq_pkg::ST_SLEEP) &&
                       boost_sleep_stby_ff && timer_tick;
  wire dly_done = (dly_ff == 16'h0);
  wire wr_ctrl = reg_wr && hit(reg_addr, `PMSEQ_ADDR_CTRL);

  // next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      pmseq_pkg::ST_ACTIVE, pmseq_pkg::ST_ALT: begin
        if (req_go_ff) begin
          unique case (req_mode_ff)
            2'b00: nxt_state = pmseq_pkg::ST_ACTIVE;
            2'b01: nxt_state = pmseq_pkg::ST_ALT;
            2'b10: nxt_state = pmseq_pkg::ST_ENTER_SLEEP;
            2'b11: nxt_state = pmseq_pkg::ST_ENTER_HIB;
          endcase
        end
      end
      pmseq_pkg::ST_ENTER_SLEEP: if (dly_done) begin
        nxt_state = pmseq_pkg::ST_SLEEP;
      end
      pmseq_pkg::ST_ENTER_HIB: if (dly_done) begin
        nxt_state = pmseq_pkg::ST_HIB;
      end
      pmseq_pkg::ST_SLEEP, pmseq_pkg::ST_HIB: if (do_wake | boost_refresh) begin
        nxt_state = pmseq_pkg::ST_RESUME;
      end
      pmseq_pkg::ST_RESUME: if (dly_done) begin
        nxt_state = pmseq_pkg::ST_ACTIVE;
      end
      default: nxt_state = pmseq_pkg::ST_ACTIVE;
    endcase
  end

  // state and delay counter
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_ff <= pmseq_pkg::ST_ACTIVE;
      dly_ff <= 16'h0;
      from_hib_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff) begin
        // load the delay for the state being entered
        if (nxt_state == pmseq_pkg::ST_RESUME) begin
          from_hib_ff <= (state_ff == pmseq_pkg::ST_HIB);
          dly_ff <= (state_ff == pmseq_pkg::ST_HIB) ?
                    16'(`PMSEQ_HIB_RESUME_CYC - 1) :
                    16'(`PMSEQ_SLEEP_RESUME_CYC - 1);
        end else begin
          dly_ff <= 16'(`PMSEQ_ENTRY_CYC - 1);
        end
      end else if (!dly_done) begin
        dly_ff <= dly_ff - 16'h1;
      end
    end
  end

  // wake arriving mid-transition is held
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pend_ff <= 1'b0;
    end else if ((state_ff == pmseq_pkg::ST_ENTER_SLEEP && any_wake) ||
                 (state_ff == pmseq_pkg::ST_ENTER_HIB && pin_wake)) begin
      // hibernate entry keeps only pin wakes pending
      pend_ff <= 1'b1;
    end else if (state_ff == pmseq_pkg::ST_RESUME) begin
      pend_ff <= 1'b0;
    end
  end

  // control registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      req_mode_ff <= 2'b00;
      req_go_ff <= 1'b0;
      wake_en_ff <= 4'h0;
      tpl_ff <= `PMSEQ_TPL_RST;
      alt_ff <= 8'h0;
      vsel_ff <= 6'h0;
      boost_sleep_stby_ff <= 1'b0;
      timer_per_ff <= 32'h0;
      irq_msk_ff <= 4'h0;
      cpu_off_ff <= 1'b0;
    end else begin
      req_go_ff <= wr_ctrl;
      if (wr_ctrl) begin
        req_mode_ff <= reg_wdata[1:0];
        cpu_off_ff <= reg_wdata[2];
      end else if (state_ff == pmseq_pkg::ST_RESUME) begin
        cpu_off_ff <= 1'b0;
      end
      if (reg_wr && hit(reg_addr, `PMSEQ_ADDR_WAKEEN)) begin
        wake_en_ff <= reg_wdata[3:0];
      end
      if (reg_wr && hit(reg_addr, `PMSEQ_ADDR_TPL)) begin
        tpl_ff <= reg_wdata[7:0];
      end
      if (reg_wr && hit(reg_addr, `PMSEQ_ADDR_ALT)) begin
        alt_ff <= reg_wdata[7:0];
      end
      if (reg_wr && hit(reg_addr, `PMSEQ_ADDR_BOOST)) begin
        // clamp to 5.0 V, step 100 mV from 1.8 V
        vsel_ff <= (reg_wdata[7:0] > `PMSEQ_VSEL_MAX) ?
                   6'(`PMSEQ_VSEL_MAX) : reg_wdata[5:0];
        boost_sleep_stby_ff <= reg_wdata[8];
      end
      if (reg_wr && hit(reg_addr, `PMSEQ_ADDR_TIMER)) begin
        timer_per_ff <= reg_wdata;
      end
      if (reg_wr && hit(reg_addr, `PMSEQ_ADDR_IRQMSK)) begin
        irq_msk_ff <= reg_wdata[3:0];
      end
    end
  end

  // periodic wake timer runs in every mode except hibernate
  always_ff @(posedge sys_clk) begin
    if (srst || timer_tick || state_ff == pmseq_pkg::ST_HIB) begin
      timer_cnt_ff <= 32'h0;
    end else if (timer_per_ff != 32'h0) begin
      timer_cnt_ff <= timer_cnt_ff + 32'h1;
    end
  end

  // sticky status, set wins over write-one clear
  wire [3:0] irq_set = {state_ff == pmseq_pkg::ST_RESUME && dly_done,
                        rst_wake && do_wake, timer_tick,
                        irq_wake && do_wake};
  wire [3:0] irq_clr = (reg_wr && hit(reg_addr, `PMSEQ_ADDR_IRQST)) ?
                       reg_wdata[3:0] : 4'h0;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_st_ff <= 4'h0;
    end else begin
      irq_st_ff <= (irq_st_ff & ~irq_clr) | irq_set;
    end
  end
  assign irq = |(irq_st_ff & irq_msk_ff);

  // gpio hold, captured on hibernate entry and kept while down
  wire hib_hold = (state_ff == pmseq_pkg::ST_ENTER_HIB) ||
                  (state_ff == pmseq_pkg::ST_HIB);
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hold_ff <= 8'h0;
      gpio_ff <= 8'h0;
    end else begin
      if (!hib_hold) begin
        hold_ff <= gpio_out_in;
      end
      gpio_ff <= hib_hold ? hold_ff : gpio_out_in;
    end
  end
  assign gpio_out_pins = gpio_ff;

  // boost oscillator, fixed rate from the system clock
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bdiv_ff <= 8'h0;
      bclk_ff <= 1'b0;
    end else if (bdiv_ff == 8'(`PMSEQ_BOOST_DIV / 2 - 1)) begin
      bdiv_ff <= 8'h0;
      bclk_ff <= ~bclk_ff;
    end else begin
      bdiv_ff <= bdiv_ff + 8'h1;
    end
  end

  // boost mode follows chip mode
  wire boost_stby = (state_ff == pmseq_pkg::ST_SLEEP &&
                     boost_sleep_stby_ff) ||
                    state_ff == pmseq_pkg::ST_HIB;
  assign boosted_supply_output = '{boost_active: ~boost_stby,
                                   boost_clk: bclk_ff & ~boost_stby,
                                   boost_vsel: vsel_ff};

  // subsystem power and mode outputs
  wire low = (state_ff == pmseq_pkg::ST_SLEEP) ||
             (state_ff == pmseq_pkg::ST_HIB) ||
             (state_ff == pmseq_pkg::ST_RESUME);
  assign subsys_pwr = (state_ff == pmseq_pkg::ST_SLEEP) ?
                      `PMSEQ_SLEEP_KEEP :
                      (state_ff == pmseq_pkg::ST_HIB) ? 8'h0 :
                      (state_ff == pmseq_pkg::ST_ALT) ? alt_ff :
                      tpl_ff;
  assign cpu_en = ~low && state_ff != pmseq_pkg::ST_ALT && ~cpu_off_ff;
  assign mode_out = (state_ff == pmseq_pkg::ST_ALT) ? pmseq_pkg::MD_ALT :
                    // resume still reports the low mode being left
                    (state_ff == pmseq_pkg::ST_RESUME) ?
                    (from_hib_ff ? pmseq_pkg::MD_HIB : pmseq_pkg::MD_SLEEP) :
                    (state_ff == pmseq_pkg::ST_SLEEP ||
                     state_ff == pmseq_pkg::ST_ENTER_SLEEP) ?
                    pmseq_pkg::MD_SLEEP :
                    (hib_hold) ? pmseq_pkg::MD_HIB : pmseq_pkg::MD_ACTIVE;
  assign startup_clk_48m = fast_startup;

  // read path, data one cycle after the strobe
  wire [31:0] rmux =
    hit(reg_addr, `PMSEQ_ADDR_CTRL) ? {29'h0, cpu_off_ff, req_mode_ff} :
    hit(reg_addr, `PMSEQ_ADDR_STAT) ? {29'h0, state_ff} :
    hit(reg_addr, `PMSEQ_ADDR_WAKEEN) ? {28'h0, wake_en_ff} :
    hit(reg_addr, `PMSEQ_ADDR_TPL) ? {24'h0, tpl_ff} :
    hit(reg_addr, `PMSEQ_ADDR_ALT) ? {24'h0, alt_ff} :
    hit(reg_addr, `PMSEQ_ADDR_BOOST) ?
      {23'h0, boost_sleep_stby_ff, 2'h0, vsel_ff} :
    hit(reg_addr, `PMSEQ_ADDR_TIMER) ? timer_per_ff :
    hit(reg_addr, `PMSEQ_ADDR_IRQST) ? {28'h0, irq_st_ff} :
    hit(reg_addr, `PMSEQ_ADDR_IRQMSK) ? {28'h0, irq_msk_ff} : 32'h0;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_ff <= 32'h0;
    end else begin
      rdata_ff <= reg_rd ? rmux : 32'h0;
    end
  end
  assign reg_rdata = rdata_ff;

  // checks
  property p_sleep_resume;
    @(posedge sys_clk) disable iff (srst)
    (state_ff == pmseq_pkg::ST_SLEEP && nxt_state == pmseq_pkg::ST_RESUME)
    |=> (state_ff == pmseq_pkg::ST_RESUME) [*8];
  endproperty
  a_sleep_resume: assert property (p_sleep_resume)
    else $error("sleep resume left early");
  property p_hib_pin_only;
    @(posedge sys_clk) disable iff (srst)
    (state_ff == pmseq_pkg::ST_HIB && !pin_wake && !pend_ff)
    |=> state_ff == pmseq_pkg::ST_HIB;
  endproperty
  a_hib_pin_only: assert property (p_hib_pin_only)
    else $error("hibernate left without pin wake");
  property p_boost_active;
    @(posedge sys_clk) disable iff (srst)
    (mode_out == pmseq_pkg::MD_ACTIVE || mode_out == pmseq_pkg::MD_ALT)
    |-> boosted_supply_output.boost_active;
  endproperty
  a_boost_active: assert property (p_boost_active)
    else $error("boost not active in active mode");
  property p_hold;
    @(posedge sys_clk) disable iff (srst)
    (state_ff == pmseq_pkg::ST_HIB && $past(state_ff) == pmseq_pkg::ST_HIB)
    |-> $stable(gpio_out_pins);
  endproperty
  a_hold: assert property (p_hold)
    else $error("gpio changed in hibernate");
  // cycles since a sleep wake, cleared once the cpu runs again
  logic [11:0] wake_age_ff;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wake_age_ff <= 12'h0;
    end else if (wake_age_ff != 12'h0) begin
      wake_age_ff <= (state_ff == pmseq_pkg::ST_ACTIVE && cpu_en) ?
                     12'h0 : wake_age_ff + 12'h1;
    end else if (state_ff == pmseq_pkg::ST_SLEEP && any_wake) begin
      wake_age_ff <= 12'h1;
    end
  end
  property p_wake_active;
    @(posedge sys_clk) disable iff (srst)
    wake_age_ff <= 12'(`PMSEQ_SLEEP_RESUME_CYC + 5);
  endproperty
  a_wake_active: assert property (p_wake_active)
    else $error("wake did not reach active");
  property p_pending;
    @(posedge sys_clk) disable iff (srst)
    (state_ff == pmseq_pkg::ST_ENTER_SLEEP && any_wake) |=> pend_ff;
  endproperty
  a_pending: assert property (p_pending)
    else $error("wake lost during entry");
  property p_sleep_pwr;
    @(posedge sys_clk) disable iff (srst)
    state_ff == pmseq_pkg::ST_SLEEP |-> subsys_pwr == `PMSEQ_SLEEP_KEEP;
  endproperty
  a_sleep_pwr: assert property (p_sleep_pwr)
    else $error("sleep resources not forced off");
  property p_vsel;
    @(posedge sys_clk) disable iff (srst)
    boosted_supply_output.boost_vsel <= 6'(`PMSEQ_VSEL_MAX);
  endproperty
  a_vsel: assert property (p_vsel)
    else $error("boost level above range");
  property p_alt;
    @(posedge sys_clk) disable iff (srst)
    state_ff == pmseq_pkg::ST_ALT |-> (subsys_pwr == alt_ff && !cpu_en);
  endproperty
  a_alt: assert property (p_alt)
    else $error("alternate active powers wrong set");
endmodule
